// ---- rtl/byte_queue_defines.vh ----
// register offsets, field positions, reset values and sizes of the byte queue
`ifndef BYTE_QUEUE_DEFINES_VH
`define BYTE_QUEUE_DEFINES_VH

`define ADDR_W 7
`define ADDR_QUEUE_CONFIG 7'h02
`define ADDR_QUEUE_THRESHOLD 7'h03
`define ADDR_QUEUE_FILL_COUNT 7'h04
`define ADDR_QUEUE_DATA_PORT 7'h05
`define ADDR_REQUEST_A 7'h06
`define ADDR_REQUEST_B 7'h07

`define CFG_CAPACITY_SELECT_BIT 7
`define CFG_NEAR_FULL_BIT 6
`define CFG_NEAR_EMPTY_BIT 5
`define CFG_QUEUE_CLEAR_BIT 4
`define CFG_THRESHOLD_MSB_BIT 2
`define CFG_FILL_UPPER_HI 1
`define CFG_FILL_UPPER_LO 0

`define REQ_SET_BIT 7
`define REQ_NEAR_FULL_BIT 6
`define REQ_NEAR_EMPTY_BIT 5

`define CFG_CAPACITY_RESET 1'b0
`define CFG_THRESHOLD_MSB_RESET 1'b0
`define THRESHOLD_RESET 8'h00
`define FILL_COUNT_RESET 10'h000
`define REQUEST_RESET 7'h00
`define PTR_RESET 7'h00

`define CAPACITY_SMALL 10'h0ff
`define CAPACITY_LARGE 10'h200
`define QUEUE_DEPTH 512
`define QUEUE_LEVEL_W 10

`endif

// ---- rtl/byte_fifo.v ----
// byte fifo with its own storage, registered read data and a run-time capacity limit
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 512,
    parameter AW = 9,
    parameter LW = 10
) (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire [LW-1:0] limit,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data_q,
    output reg [LW-1:0] level_q
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    wire push;
    wire pop;

    // full follows the selected capacity, not the physical depth
    assign in_ready = (level_q < limit);
    assign out_valid = (level_q != {LW{1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // read data is a register: it holds the byte taken by the last pop
    always @(posedge clk) begin
        if (!rst_n) begin
            out_data_q <= {WIDTH{1'b0}};
        end else if (pop) begin
            out_data_q <= mem[rd_ptr_q];
        end
    end

    always @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            level_q <= {LW{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                level_q <= level_q + {{(LW-1){1'b0}}, 1'b1};
            end else if (pop && !push) begin
                level_q <= level_q - {{(LW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ---- rtl/rf_frontend_byte_queue.v ----
// register-mapped byte queue with threshold flags, fill count and request registers
`timescale 1ns/1ps
`include "byte_queue_defines.vh"

module rf_frontend_byte_queue #(
    parameter DEPTH = `QUEUE_DEPTH
) (
    input wire clk,
    input wire rst_n,
    input wire acc_start,
    input wire [`ADDR_W-1:0] acc_addr,
    input wire acc_wr,
    input wire acc_rd,
    input wire [7:0] acc_wdata,
    input wire [4:0] events_a,
    input wire [6:0] events_b,
    output reg [7:0] rdata_q,
    output reg rvalid_q,
    output reg [`ADDR_W-1:0] ptr_q,
    output reg near_full_flag_q,
    output reg near_empty_flag_q,
    output reg [6:0] request_register_a_q,
    output reg [6:0] request_register_b_q
);
    localparam LW = `QUEUE_LEVEL_W;

    reg queue_capacity_select_q;
    reg threshold_msb_q;
    reg [7:0] threshold_low_byte_q;
    reg rd_stage_q;
    reg [`ADDR_W-1:0] rd_addr_q;
    reg rd_popped_q;

    wire [`ADDR_W-1:0] addr_now;
    wire wr_cfg;
    wire wr_thr;
    wire wr_data;
    wire wr_req_a;
    wire wr_req_b;
    wire rd_data;
    wire queue_clear;
    wire [LW-1:0] capacity;
    wire [LW-1:0] threshold;
    wire [LW-1:0] fill_count;
    wire [LW-1:0] fill_seen;
    wire [LW-1:0] room;
    wire near_full_d;
    wire near_empty_d;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg [7:0] rmux;
    reg [6:0] req_a_d;
    reg [6:0] req_b_d;
    wire [6:0] hw_set_a;

    // a fresh start address takes effect in the same cycle as its access
    assign addr_now = acc_start ? acc_addr : ptr_q;

    assign wr_cfg = acc_wr && (addr_now == `ADDR_QUEUE_CONFIG);
    assign wr_thr = acc_wr && (addr_now == `ADDR_QUEUE_THRESHOLD);
    assign wr_data = acc_wr && (addr_now == `ADDR_QUEUE_DATA_PORT);
    assign wr_req_a = acc_wr && (addr_now == `ADDR_REQUEST_A);
    assign wr_req_b = acc_wr && (addr_now == `ADDR_REQUEST_B);
    assign rd_data = acc_rd && !acc_wr && (addr_now == `ADDR_QUEUE_DATA_PORT);

    assign queue_clear = wr_cfg && acc_wdata[`CFG_QUEUE_CLEAR_BIT];

    assign capacity = queue_capacity_select_q ? `CAPACITY_SMALL : `CAPACITY_LARGE;

    assign threshold = {1'b0, (queue_capacity_select_q ? 1'b0 : threshold_msb_q), threshold_low_byte_q};

    assign room = capacity - fill_count;

    assign near_full_d = (fill_count <= capacity) && (room <= threshold);

    assign near_empty_d = (fill_count <= threshold);

    // hide upper count in small mode
    assign fill_seen = queue_capacity_select_q ? {2'b00, fill_count[7:0]} : fill_count;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(9),
        .LW(LW)
    ) u_queue (
        .clk(clk),
        .rst_n(rst_n),
        .flush(queue_clear),
        .limit(capacity),
        .in_valid(wr_data),
        .in_ready(fifo_in_ready),
        .in_data(acc_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(rd_data),
        .out_data_q(fifo_out_data),
        .level_q(fill_count)
    );

    always @(posedge clk) begin
        if (!rst_n) begin
            ptr_q <= `PTR_RESET;
        end else if (acc_wr || acc_rd) begin
            if (addr_now == `ADDR_QUEUE_DATA_PORT) begin
                ptr_q <= addr_now;
            end else begin
                ptr_q <= addr_now + 7'h01;
            end
        end else if (acc_start) begin
            ptr_q <= acc_addr;
        end
    end

    // config and threshold registers
    // the capacity bit takes effect at once; clearing first is up to software
    always @(posedge clk) begin
        if (!rst_n) begin
            queue_capacity_select_q <= `CFG_CAPACITY_RESET;
            threshold_msb_q <= `CFG_THRESHOLD_MSB_RESET;
            threshold_low_byte_q <= `THRESHOLD_RESET;
        end else begin
            if (wr_cfg) begin
                queue_capacity_select_q <= acc_wdata[`CFG_CAPACITY_SELECT_BIT];
                threshold_msb_q <= acc_wdata[`CFG_THRESHOLD_MSB_BIT];
            end
            if (wr_thr) begin
                threshold_low_byte_q <= acc_wdata;
            end
        end
    end

    // flags start low so the first evaluation after reset can latch events
    always @(posedge clk) begin
        if (!rst_n) begin
            near_full_flag_q <= 1'b0;
            near_empty_flag_q <= 1'b0;
        end else begin
            near_full_flag_q <= near_full_d;
            near_empty_flag_q <= near_empty_d;
        end
    end

    assign hw_set_a = {near_full_d & ~near_full_flag_q, near_empty_d & ~near_empty_flag_q, events_a};

    // set or clear by bit 7
    // hardware set wins over a software clear in the same cycle
    always @* begin
        req_a_d = request_register_a_q;
        req_b_d = request_register_b_q;
        if (wr_req_a) begin
            if (acc_wdata[`REQ_SET_BIT]) begin
                req_a_d = request_register_a_q | acc_wdata[6:0];
            end else begin
                req_a_d = request_register_a_q & ~acc_wdata[6:0];
            end
        end
        if (wr_req_b) begin
            if (acc_wdata[`REQ_SET_BIT]) begin
                req_b_d = request_register_b_q | acc_wdata[6:0];
            end else begin
                req_b_d = request_register_b_q & ~acc_wdata[6:0];
            end
        end
        req_a_d = req_a_d | hw_set_a;
        req_b_d = req_b_d | events_b;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            request_register_a_q <= `REQUEST_RESET;
            request_register_b_q <= `REQUEST_RESET;
        end else begin
            request_register_a_q <= req_a_d;
            request_register_b_q <= req_b_d;
        end
    end

    // two-stage read: the fifo byte is only ready one cycle after the pop
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_stage_q <= 1'b0;
            rd_addr_q <= `PTR_RESET;
            rd_popped_q <= 1'b0;
        end else begin
            rd_stage_q <= acc_rd && !acc_wr;
            rd_addr_q <= addr_now;
            rd_popped_q <= rd_data && fifo_out_valid;
        end
    end

    always @* begin
        case (rd_addr_q)
            // msb reads zero in small mode
            `ADDR_QUEUE_CONFIG: begin
                rmux = {queue_capacity_select_q, near_full_flag_q, near_empty_flag_q, 1'b0, 1'b0,
                        threshold[8], fill_seen[9:8]};
            end
            `ADDR_QUEUE_THRESHOLD: begin
                rmux = threshold_low_byte_q;
            end
            `ADDR_QUEUE_FILL_COUNT: begin
                rmux = fill_seen[7:0];
            end
            `ADDR_QUEUE_DATA_PORT: begin
                rmux = rd_popped_q ? fifo_out_data : 8'h00;
            end
            `ADDR_REQUEST_A: begin
                rmux = {1'b0, request_register_a_q};
            end
            `ADDR_REQUEST_B: begin
                rmux = {1'b0, request_register_b_q};
            end
            default: begin
                rmux = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_stage_q;
            if (rd_stage_q) begin
                rdata_q <= rmux;
            end
        end
    end
endmodule

// ---- dv/rf_frontend_byte_queue_sva.sv ----
// concurrent checks on the byte queue register port, pointer and request bits
`timescale 1ns/1ps
`include "byte_queue_defines.vh"
module byte_queue_checker (
    input wire clk,
    input wire rst_n,
    input wire acc_start,
    input wire [`ADDR_W-1:0] acc_addr,
    input wire acc_wr,
    input wire acc_rd,
    input wire [7:0] acc_wdata,
    input wire [6:0] events_b,
    input wire [7:0] rdata_q,
    input wire rvalid_q,
    input wire [`ADDR_W-1:0] ptr_q,
    input wire near_full_flag_q,
    input wire near_empty_flag_q,
    input wire [6:0] request_register_a_q,
    input wire [6:0] request_register_b_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [`ADDR_W-1:0] cur_addr = acc_start ? acc_addr : ptr_q;
    wire taken = acc_wr || acc_rd;
    wire a_clr6 = acc_wr && cur_addr == `ADDR_REQUEST_A && !acc_wdata[7] && acc_wdata[6];
    wire b_clr = acc_wr && cur_addr == `ADDR_REQUEST_B && !acc_wdata[7] && events_b == 7'h00;
    chk_read_latency: assert property (acc_rd && !acc_wr |-> ##2 rvalid_q)
        else $error("read answer late");
    chk_port_ptr_hold: assert property (taken && cur_addr == `ADDR_QUEUE_DATA_PORT |=> ptr_q == 7'h05)
        else $error("pointer moved on data port");
    chk_ptr_advance: assert property (taken && cur_addr != 7'h05 |=> ptr_q == $past(cur_addr) + 7'h01)
        else $error("pointer did not advance");
    chk_full_event: assert property ($rose(near_full_flag_q) |-> request_register_a_q[6])
        else $error("near full event missed");
    chk_empty_event: assert property ($rose(near_empty_flag_q) |-> request_register_a_q[5])
        else $error("near empty event missed");
    chk_event_hold: assert property (request_register_a_q[6] && !a_clr6 |=> request_register_a_q[6])
        else $error("near full event lost");
    chk_req_clear: assert property (b_clr |=> (request_register_b_q & $past(acc_wdata[6:0])) == 7'h00)
        else $error("request bits not cleared");
    chk_clear_reads_zero: assert property (rvalid_q && $past(cur_addr == 7'h02, 2) |-> rdata_q[4:3] == 2'b00)
        else $error("clear bit read as one");
endmodule
bind rf_frontend_byte_queue byte_queue_checker byte_queue_checker_inst (.clk(clk), .rst_n(rst_n),
    .acc_start(acc_start), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
    .events_b(events_b), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .ptr_q(ptr_q),
    .near_full_flag_q(near_full_flag_q), .near_empty_flag_q(near_empty_flag_q),
    .request_register_a_q(request_register_a_q), .request_register_b_q(request_register_b_q));

// ---- dv/host_port_model.sv ----
// host side model driving the register port and the hardware event inputs
`timescale 1ns/1ps
module host_port_model (
    input wire clk,
    output logic acc_start,
    output logic [6:0] acc_addr,
    output logic acc_wr,
    output logic acc_rd,
    output logic [7:0] acc_wdata,
    output logic [4:0] events_a,
    output logic [6:0] events_b
);
    initial begin
        {acc_start, acc_addr, acc_wr, acc_rd, acc_wdata, events_a, events_b} = '0;
    end
    // no handshake: a request stands for exactly one edge
    task automatic acc(input logic st, input logic [6:0] a, input logic wr, input logic [7:0] d);
        @(posedge clk);
        #1;
        acc_start = st;
        acc_addr = a;
        acc_wr = wr;
        acc_rd = !wr;
        acc_wdata = d;
    endtask
    // released lines toggle so a stale value never looks live
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            {acc_start, acc_wr, acc_rd, events_a, events_b} = '0;
            acc_addr = ~acc_addr;
            acc_wdata = ~acc_wdata;
        end
    endtask
    task automatic pulse(input logic [4:0] ea, input logic [6:0] eb);
        @(posedge clk);
        #1;
        {acc_start, acc_wr, acc_rd} = '0;
        events_a = ea;
        events_b = eb;
    endtask
endmodule

// ---- dv/rf_frontend_byte_queue_test.sv ----
// self-checking bench for the register-mapped byte queue
`timescale 1ns/1ps
`include "byte_queue_defines.vh"
module rf_frontend_byte_queue_test;
    logic clk = 0;
    logic rst_n = 0;
    wire acc_start, acc_wr, acc_rd, rvalid_q, near_full_flag_q, near_empty_flag_q;
    wire [6:0] acc_addr, ptr_q, events_b, request_register_a_q, request_register_b_q;
    wire [7:0] acc_wdata, rdata_q;
    wire [4:0] events_a;
    logic [7:0] expect_list[$];
    logic [7:0] sent[$];
    logic [31:0] r;
    int fails = 0;
    int cmp_count = 0;
    rf_frontend_byte_queue rf_frontend_byte_queue_inst (.clk(clk), .rst_n(rst_n), .acc_start(acc_start),
        .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .events_a(events_a),
        .events_b(events_b), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .ptr_q(ptr_q),
        .near_full_flag_q(near_full_flag_q), .near_empty_flag_q(near_empty_flag_q),
        .request_register_a_q(request_register_a_q), .request_register_b_q(request_register_b_q));
    host_port_model host_port_model_inst (.clk(clk), .acc_start(acc_start), .acc_addr(acc_addr),
        .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .events_a(events_a), .events_b(events_b));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %0t read %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_port_model_inst.acc(1'b1, a, 1'b1, d);
    endtask
    task automatic rd(input logic st, input logic [6:0] a, input logic [7:0] want);
        logic [7:0] junk;
        junk = $urandom;
        expect_list.push_back(want);
        host_port_model_inst.acc(st, a, 1'b0, junk);
    endtask
    task automatic push(input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = $urandom;
            sent.push_back(b);
            host_port_model_inst.acc(i == 0 || b[0], 7'h05, 1'b1, b);
        end
    endtask
    // lets answers drain and the lagging flags settle
    task automatic done(input int n);
        host_port_model_inst.idle(4);
        $display("test %0d done", n);
    endtask
    always @(posedge clk) begin
        if (rvalid_q === 1'b1) begin
            if (expect_list.size() == 0) begin
                fails++;
                $display("CHECK FAILED %0t answer without read", $time);
            end else begin
                check(rdata_q, expect_list.pop_front());
            end
        end
    end
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(32'ha74db795));
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        host_port_model_inst.idle(3);
        rd(1, `ADDR_QUEUE_CONFIG, 8'h20);
        rd(0, 7'h03, 8'h00);
        rd(0, 7'h04, 8'h00);
        rd(1, `ADDR_REQUEST_A, 8'h20);
        rd(0, 7'h07, 8'h00);
        rd(0, 7'h08, 8'h00);
        done(1);
        wr(`ADDR_QUEUE_THRESHOLD, 8'h03);
        push(5);
        host_port_model_inst.idle(3);
        rd(1, `ADDR_QUEUE_FILL_COUNT, 8'h05);
        rd(1, `ADDR_QUEUE_CONFIG, 8'h00);
        for (int i = 0; i < 5; i++)
            rd(i == 0, 7'h05, sent.pop_front());
        rd(1, 7'h05, 8'h00);
        done(2);
        wr(`ADDR_QUEUE_CONFIG, 8'h80);
        wr(`ADDR_REQUEST_A, 8'h7f);
        push(256);
        host_port_model_inst.idle(3);
        rd(1, 7'h04, 8'hff);
        rd(1, 7'h02, 8'hc0);
        rd(1, 7'h06, 8'h40);
        wr(7'h06, 8'h7f);
        rd(1, 7'h06, 8'h00);
        wr(7'h02, 8'h90);
        host_port_model_inst.idle(3);
        rd(1, 7'h04, 8'h00);
        rd(1, 7'h02, 8'ha0);
        rd(1, 7'h06, 8'h20);
        done(3);
        wr(7'h02, 8'h04);
        wr(7'h03, 8'h00);
        push(300);
        host_port_model_inst.idle(3);
        rd(1, 7'h02, 8'h45);
        rd(1, 7'h04, 8'h2c);
        wr(7'h02, 8'h14);
        host_port_model_inst.idle(3);
        wr(7'h02, 8'h84);
        push(4);
        host_port_model_inst.idle(3);
        rd(1, 7'h02, 8'h80);
        wr(7'h02, 8'h90);
        done(4);
        sent.delete();
        wr(7'h06, 8'h7f);
        wr(7'h07, 8'h7f);
        r = $urandom;
        host_port_model_inst.pulse(r[4:0], r[14:8]);
        host_port_model_inst.idle(2);
        rd(1, 7'h06, {3'b000, r[4:0]});
        rd(0, 7'h07, {1'b0, r[14:8]});
        wr(7'h07, 8'hff);
        rd(1, 7'h07, 8'h7f);
        wr(7'h07, 8'h05);
        rd(1, 7'h07, 8'h7a);
        done(5);
        r = $urandom;
        wr(7'h02, 8'h90);
        wr(7'h03, r[7:0]);
        push(r[15:8]);
        host_port_model_inst.idle(3);
        rd(1, 7'h02, {1'b1, ((9'd255 - r[15:8]) <= r[7:0]), (r[15:8] <= r[7:0]), 5'h00});
        rd(1, 7'h04, r[15:8]);
        done(6);
        conclude();
    end
endmodule
